/* File: logic/flash_sector_protect_ctrl.sv */
// Sector protection and access control of a dual-bank flash.
// Assumes bus pins and the supply detector are asynchronous and that
// the array, read mux and nonvolatile mode bit share sys_clk.
//
// Summary of operation
// - Write-protect low blocks two outermost sectors
// - Outer sectors still obey their protection bits
// - Password private; verify hidden once mode locked
// - Entry maps otp region by ordering option
// - Rest of overlaid sector reads invalid
// - Lock operations: otp hidden, small bank status
// - Overlaid sector dynamic bit write ignored
// - Overlaid sector dynamic bit verify invalid
// - Bypass, query, accelerate, suspend, resume ignored
// - Sector erase never erases otp region
// - Chip erase spares overlaid sector
// - Entry allowed in suspend; resume blocked
// - Protection bit set forbids otp programming
// - Volatile lock set after reset, password mode
// - Only matching unlock clears lock, password mode
// - Reset or lock-set command sets lock, password mode
// - Persistent mode: reset clears, command sets
// - Persistent mode ignores password unlock
// - Low supply rejects writes and resets logic
// - Write needs select, strobe low, output high
// - No command on power-up write edge
// - Dynamic bit decides when persistent bit clear
// - Program or sector erase on protected sector polls, changes nothing
// - Unlock compare delayed; mismatch changes nothing
`timescale 1ns/100ps
`default_nettype none
`include "flash_prot_defines.svh"
module flash_sector_protect_ctrl #(
    parameter int ERS_POLL_CYC =
        (`T_PROT_ERS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Flash bus pins, asynchronous
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic wp_n,
    input wire logic [18:0] addr,
    input wire logic [31:0] data,
    // Supply detector, asynchronous
    input wire logic lockout_voltage_low,
    // Configuration, same clock
    input wire logic opt01,
    input wire logic pw_mode_locked,
    // Array control
    output var flash_prot_pkg::grant_t grant_r,
    output logic [`SECT_COUNT-1:0] ers_mask_r,
    output logic [18:0] op_addr_r,
    output logic [31:0] op_data_r,
    // Read path
    output var flash_prot_pkg::rd_sel_t rd_sel_r,
    output logic [31:0] verify_data_r,
    output logic verify_valid_r,
    // Status
    output logic busy_r,
    output logic persistent_bit_lock_r,
    output logic otp_enabled_r,
    output logic suspended_r
);
    localparam int PGM_POLL_CYC =
        (`T_PROT_PGM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int PW_CHECK_CYC =
        (`T_PW_CHECK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int NV_OP_CYC =
        (`T_NV_OP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    flash_prot_pkg::pins_t pin_s;
    logic [18:0] addr_s;
    logic [31:0] data_s;
    // Address and data are synchronised too; they are stable around
    // the strobe edge, so skew between bits does no harm.
    sync2 #(.WIDTH(56)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d({ce_n, we_n, oe_n, wp_n, lockout_voltage_low, addr, data}),
        .q({pin_s, addr_s, data_s})
    );

    flash_prot_pkg::state_t state_r, state_nxt;
    flash_prot_pkg::nv_op_t nv_op_r, nv_op_nxt;
    logic wr_prev_r, armed_r, init_r, match_r, poll_small_r, otp_prot_r;
    logic [1:0] settle_r;
    logic [5:0] nv_sect_r;
    logic nv_half_r;
    logic [31:0] nv_data_r, try_lo_r;
    logic [31:0] pw_r [2];
    logic [`SECT_COUNT-1:0] pers_r, dyn_r;

    function automatic logic [5:0] sect_of(input logic [18:0] a);
        if (a[18:14] == `TAG_LOW) begin
            sect_of = {3'h0, a[13:11]};
        end else if (a[18:14] == `TAG_TOP) begin
            sect_of = `SECT_TOP_FIRST + {3'h0, a[13:11]};
        end else begin
            sect_of = {1'b0, a[18:14]} + `SECT_MID_OFS;
        end
    endfunction

    wire vcc_low = pin_s.vcc_low;
    wire wr_level = !pin_s.ce_n && !pin_s.we_n && pin_s.oe_n;
    wire take = wr_prev_r && pin_s.we_n && armed_r && !vcc_low;
    wire idle = state_r == flash_prot_pkg::ST_IDLE;
    wire acc = take && idle;
    wire [7:0] op = data_s[7:0];
    wire arg = data_s[`ARG_BIT];

    wire [5:0] cmd_sect = sect_of(addr_s);
    wire [`SECT_COUNT-1:0] onehot = `SECT_COUNT'(1) << cmd_sect;
    wire [`SECT_COUNT-1:0] ovl_mask = opt01 ? `OVL_MASK_01 : `OVL_MASK_00;
    wire [`SECT_COUNT-1:0] wp_mask = pin_s.wp_n ? '0 :
        (opt01 ? `WP_MASK_01 : `WP_MASK_00);
    wire in_otp = opt01 ? (addr_s >= `OTP01_LO && addr_s <= `OTP01_HI)
                        : (addr_s <= `OTP00_HI);
    wire in_inv = opt01 ? (addr_s >= `INV01_LO && addr_s <= `INV01_HI)
                        : (addr_s >= `INV00_LO && addr_s <= `INV00_HI);
    wire small_bank = addr_s[18:17] ==
        (opt01 ? `BANK_SMALL_01 : `BANK_SMALL_00);
    wire ovl_hit = otp_enabled_r && ((onehot & ovl_mask) != '0);
    wire otp_hit = otp_enabled_r && in_otp;
    // dynamic bit used when persistent clear
    wire sect_prot = (onehot & (pers_r | dyn_r)) != '0;
    wire wp_block = (onehot & wp_mask) != '0;
    wire pe_blocked = sect_prot || wp_block;

    wire banned = otp_enabled_r && (op == `CMD_UB_ENTRY ||
        op == `CMD_UB_PGM || op == `CMD_CFI || op == `CMD_ACC_PGM ||
        op == `CMD_SUSPEND || op == `CMD_RESUME);
    wire ok = acc && !banned;
    wire is_pgm = ok && op == `CMD_PGM;
    wire is_sers = ok && op == `CMD_SECT_ERS;
    wire is_cers = ok && op == `CMD_CHIP_ERS;
    wire is_lock_set = ok && op == `CMD_LOCK_SET;
    wire is_unlock = ok && op == `CMD_PW_UNLOCK;

    wire pgm_ok = is_pgm && !otp_hit && !pe_blocked;
    wire pgm_prot = is_pgm && !otp_hit && pe_blocked;
    wire otp_pgm_ok = is_pgm && otp_hit && !otp_prot_r;
    wire sers_ok = is_sers && !pe_blocked && !ovl_hit;
    wire sers_prot = is_sers && pe_blocked && !ovl_hit;
    wire [`SECT_COUNT-1:0] chip_mask = ~(pers_r | dyn_r | wp_mask |
        (otp_enabled_r ? ovl_mask : '0));
    wire cers_ok = is_cers && chip_mask != '0;
    wire poll_go = pgm_prot || sers_prot;
    wire pers_pgm_go = ok && op == `CMD_PERS_PGM && !persistent_bit_lock_r;
    wire pers_ers_go = ok && op == `CMD_PERS_ERS && !persistent_bit_lock_r;
    wire pw_pgm_go = ok && op == `CMD_PW_PGM && !pw_mode_locked;
    wire unlock_go = is_unlock && pw_mode_locked && addr_s[0];
    wire unlock_lo = is_unlock && pw_mode_locked && !addr_s[0];
    wire nv_go = pers_pgm_go || pers_ers_go || pw_pgm_go || unlock_go;
    wire suspend_ok = ok && op == `CMD_SUSPEND;
    wire resume_ok = ok && op == `CMD_RESUME && suspended_r;

    logic tmr_done;
    wire tmr_start = poll_go || nv_go;
    wire [15:0] tmr_load = pgm_prot ? 16'(PGM_POLL_CYC) :
        sers_prot ? 16'(ERS_POLL_CYC) :
        unlock_go ? 16'(PW_CHECK_CYC) : 16'(NV_OP_CYC);
    cycle_timer #(.WIDTH(16)) u_tmr (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(tmr_start),
        .clear(vcc_low),
        .load(tmr_load),
        .done(tmr_done)
    );
    wire nv_done = state_r == flash_prot_pkg::ST_NV_BUSY && tmr_done;
    wire unlock_ok = nv_done && nv_op_r == flash_prot_pkg::NV_UNLOCK &&
        match_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            flash_prot_pkg::ST_IDLE: begin
                if (poll_go) begin
                    state_nxt = flash_prot_pkg::ST_POLL;
                end else if (nv_go) begin
                    state_nxt = flash_prot_pkg::ST_NV_BUSY;
                end
            end
            flash_prot_pkg::ST_POLL,
            flash_prot_pkg::ST_NV_BUSY: begin
                if (tmr_done) begin
                    state_nxt = flash_prot_pkg::ST_IDLE;
                end
            end
            default: state_nxt = flash_prot_pkg::ST_IDLE;
        endcase
        if (vcc_low) begin
            state_nxt = flash_prot_pkg::ST_IDLE;
        end
    end

    assign nv_op_nxt = unlock_go ? flash_prot_pkg::NV_UNLOCK :
        pers_pgm_go ? flash_prot_pkg::NV_PERS_PGM :
        pers_ers_go ? flash_prot_pkg::NV_PERS_ERS :
        flash_prot_pkg::NV_PW_PGM;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= flash_prot_pkg::ST_IDLE;
            busy_r <= 1'b0;
            wr_prev_r <= 1'b0;
            armed_r <= 1'b0;
            settle_r <= 2'h0;
            init_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            busy_r <= state_nxt != flash_prot_pkg::ST_IDLE;
            wr_prev_r <= wr_level;
            // Synced pins show reset zeros for two edges; do not arm on them
            settle_r <= {settle_r[0], 1'b1};
            armed_r <= !vcc_low && settle_r[1] && (armed_r || !wr_level);
            init_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nv_op_r <= flash_prot_pkg::NV_UNLOCK;
            nv_sect_r <= 6'h00;
            nv_half_r <= 1'b0;
            nv_data_r <= 32'h0000_0000;
            match_r <= 1'b0;
            poll_small_r <= 1'b0;
        end else if (tmr_start) begin
            nv_op_r <= nv_op_nxt;
            nv_sect_r <= cmd_sect;
            nv_half_r <= addr_s[0];
            nv_data_r <= data_s;
            // Low byte of each word carries the command code
            match_r <= {data_s[31:8], try_lo_r[31:8]} ==
                {pw_r[1][31:8], pw_r[0][31:8]};
            poll_small_r <= small_bank;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pw_r[0] <= 32'h0000_0000;
            pw_r[1] <= 32'h0000_0000;
            try_lo_r <= 32'h0000_0000;
        end else begin
            if (nv_done && nv_op_r == flash_prot_pkg::NV_PW_PGM) begin
                pw_r[nv_half_r] <= nv_data_r;
            end
            if (unlock_lo) begin
                try_lo_r <= data_s;
            end
        end
    end

    wire dyn_wr = ok && op == `CMD_DYN_WR && !ovl_hit;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dyn_r <= '0;
            pers_r <= '0;
            otp_prot_r <= 1'b0;
        end else begin
            if (dyn_wr) begin
                dyn_r[cmd_sect] <= arg;
            end
            if (nv_done && nv_op_r == flash_prot_pkg::NV_PERS_ERS) begin
                pers_r <= '0;
            end else if (nv_done && nv_op_r == flash_prot_pkg::NV_PERS_PGM) begin
                pers_r[nv_sect_r] <= 1'b1;
            end
            if (ok && op == `CMD_OTP_PROT) begin
                otp_prot_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            persistent_bit_lock_r <= 1'b1;
        end else if (init_r || vcc_low) begin
            persistent_bit_lock_r <= pw_mode_locked;
        end else if (is_lock_set) begin
            persistent_bit_lock_r <= 1'b1;
        end else if (unlock_ok) begin
            persistent_bit_lock_r <= 1'b0;
        end
    end

    // entry kept apart from suspend state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            otp_enabled_r <= 1'b0;
            suspended_r <= 1'b0;
        end else if (vcc_low) begin
            otp_enabled_r <= 1'b0;
            suspended_r <= 1'b0;
        end else begin
            if (acc && op == `CMD_OTP_ENTRY) begin
                otp_enabled_r <= 1'b1;
            end else if (acc && op == `CMD_OTP_EXIT) begin
                otp_enabled_r <= 1'b0;
            end
            if (suspend_ok) begin
                suspended_r <= 1'b1;
            end else if (resume_ok) begin
                suspended_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            grant_r <= '0;
            ers_mask_r <= '0;
            op_addr_r <= 19'h00000;
            op_data_r <= 32'h0000_0000;
        end else begin
            grant_r <= '{pgm: pgm_ok, otp_pgm: otp_pgm_ok,
                ers: sers_ok || cers_ok, suspend: suspend_ok,
                resume: resume_ok};
            if (acc) begin
                ers_mask_r <= is_cers ? chip_mask : onehot;
                op_addr_r <= addr_s;
                op_data_r <= data_s;
            end
        end
    end

    wire is_vfy = ok && (op == `CMD_LOCK_VFY || op == `CMD_DYN_VFY ||
        op == `CMD_PERS_VFY || op == `CMD_PW_VFY);
    wire [31:0] vfy_nxt =
        op == `CMD_LOCK_VFY ? {31'h0000_0000, persistent_bit_lock_r} :
        op == `CMD_PERS_VFY ? {31'h0000_0000, pers_r[cmd_sect]} :
        op == `CMD_PW_VFY ? (pw_mode_locked ? 32'h0000_0000 :
            pw_r[addr_s[0]]) :
        ovl_hit ? `INVALID_DATA : {31'h0000_0000, dyn_r[cmd_sect]};
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            verify_data_r <= 32'h0000_0000;
            verify_valid_r <= 1'b0;
        end else begin
            verify_valid_r <= is_vfy;
            if (is_vfy) begin
                verify_data_r <= vfy_nxt;
            end
        end
    end

    // lock ops: status in small bank, otp hidden; polling: status in the polled bank
    wire nv_busy = state_r == flash_prot_pkg::ST_NV_BUSY;
    wire rd_status = (nv_busy && small_bank) ||
        (state_r == flash_prot_pkg::ST_POLL && small_bank == poll_small_r);
    wire rd_inv = otp_enabled_r && (in_inv || (in_otp && nv_busy));
    wire flash_prot_pkg::rd_sel_t rd_nxt =
        rd_status ? flash_prot_pkg::RD_STATUS :
        rd_inv ? flash_prot_pkg::RD_INVALID :
        otp_hit ? flash_prot_pkg::RD_OTP : flash_prot_pkg::RD_ARRAY;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_sel_r <= flash_prot_pkg::RD_ARRAY;
        end else begin
            rd_sel_r <= rd_nxt;
        end
    end

    AST_WP_BLOCK: assert property (@(posedge sys_clk) disable iff (rst)
        (acc && op == `CMD_PGM && wp_block) |=> !grant_r.pgm)
        else $error("program granted on pin-protected sector");
    AST_PROT_POLL: assert property (@(posedge sys_clk) disable iff (rst)
        (pgm_prot && !vcc_low) |-> ##PGM_POLL_CYC busy_r ##1 !busy_r)
        else $error("protected program poll length wrong");
    AST_BIT_PROT: assert property (@(posedge sys_clk) disable iff (rst)
        (is_pgm && !otp_hit && sect_prot) |=> !grant_r.pgm && busy_r)
        else $error("program granted on protected sector");
    AST_OTP_MAP: assert property (@(posedge sys_clk) disable iff (rst)
        (otp_hit && idle && !take) |=> rd_sel_r == flash_prot_pkg::RD_OTP)
        else $error("otp window not mapped");
    AST_INVALID: assert property (@(posedge sys_clk) disable iff (rst)
        (otp_enabled_r && in_inv && !rd_status)
        |=> rd_sel_r == flash_prot_pkg::RD_INVALID)
        else $error("overlaid remainder not invalid");
    AST_STATUS: assert property (@(posedge sys_clk) disable iff (rst)
        (nv_busy && small_bank) |=> rd_sel_r == flash_prot_pkg::RD_STATUS)
        else $error("small bank not showing status");
    AST_DYN_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        (ok && op == `CMD_DYN_WR && ovl_hit) |=> dyn_r == $past(dyn_r))
        else $error("overlaid dynamic bit changed");
    AST_RESUME: assert property (@(posedge sys_clk) disable iff (rst)
        (take && otp_enabled_r && op == `CMD_RESUME)
        |=> !grant_r.resume && $stable(suspended_r))
        else $error("resume accepted while otp mapped");
    AST_LOCK_SET: assert property (@(posedge sys_clk) disable iff (rst)
        (is_lock_set && !init_r) |=> persistent_bit_lock_r)
        else $error("lock-set did not set lock");
    AST_PW_IGNORE: assert property (@(posedge sys_clk) disable iff (rst)
        (is_unlock && !pw_mode_locked) |=> !busy_r && !nv_busy)
        else $error("unlock acted in persistent mode");
    AST_LOW_VCC: assert property (@(posedge sys_clk) disable iff (rst)
        vcc_low |=> !busy_r && !otp_enabled_r && grant_r == '0)
        else $error("low supply did not reset control");
endmodule // flash_sector_protect_ctrl
`default_nettype wire

/* File: include/flash_prot_defines.svh */
// Constants of the sector protection controller: command codes,
// address windows, sector masks and timing figures.
// Assumes one 19-bit word address bus and a 100 MHz system clock.
`ifndef FLASH_PROT_DEFINES_SVH
`define FLASH_PROT_DEFINES_SVH
`define CMD_PGM 8'hA0
`define CMD_SECT_ERS 8'h30
`define CMD_CHIP_ERS 8'h10
`define CMD_OTP_ENTRY 8'h88
`define CMD_OTP_EXIT 8'h90
`define CMD_DYN_WR 8'h48
`define CMD_DYN_VFY 8'h58
`define CMD_PERS_PGM 8'h68
`define CMD_PERS_ERS 8'h60
`define CMD_PERS_VFY 8'h6A
`define CMD_LOCK_SET 8'h78
`define CMD_LOCK_VFY 8'h7A
`define CMD_PW_PGM 8'h38
`define CMD_PW_VFY 8'hC8
`define CMD_PW_UNLOCK 8'h28
`define CMD_OTP_PROT 8'h8A
`define CMD_UB_ENTRY 8'h20
`define CMD_UB_PGM 8'hA8
`define CMD_CFI 8'h98
`define CMD_ACC_PGM 8'hA2
`define CMD_SUSPEND 8'hB0
`define CMD_RESUME 8'h3A
`define ARG_BIT 8
`define OTP00_LO 19'h00000
`define OTP00_HI 19'h0003F
`define OTP01_LO 19'h7FFC0
`define OTP01_HI 19'h7FFFF
`define INV00_LO 19'h00040
`define INV00_HI 19'h007FF
`define INV01_LO 19'h7F800
`define INV01_HI 19'h7FFBF
`define SECT_COUNT 46
`define TAG_LOW 5'h00
`define TAG_TOP 5'h1F
`define SECT_TOP_FIRST 6'h26
`define SECT_MID_OFS 6'h07
`define BANK_SMALL_00 2'h0
`define BANK_SMALL_01 2'h3
`define WP_MASK_00 46'h3000_0000_0000
`define WP_MASK_01 46'h0000_0000_0003
`define OVL_MASK_00 46'h0000_0000_0001
`define OVL_MASK_01 46'h2000_0000_0000
`define INVALID_DATA 32'hFFFF_FFFF
`define CLK_PERIOD_NS 10
`define T_PROT_PGM_NS 1000
`define T_PROT_ERS_NS 50000
`define T_PW_CHECK_NS 2000
`define T_NV_OP_NS 1000
`endif

/* File: include/flash_prot_pkg.sv */
// Types shared by the sector protection controller files.
// Assumes nothing of its surroundings.
package flash_prot_pkg;
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic wp_n;
        logic vcc_low;
    } pins_t;
    typedef struct packed {
        logic pgm;
        logic otp_pgm;
        logic ers;
        logic suspend;
        logic resume;
    } grant_t;
    typedef enum logic [1:0] {RD_ARRAY, RD_OTP, RD_INVALID, RD_STATUS} rd_sel_t;
    typedef enum logic [1:0] {ST_IDLE, ST_POLL, ST_NV_BUSY} state_t;
    typedef enum logic [1:0] {NV_UNLOCK, NV_PERS_PGM, NV_PERS_ERS, NV_PW_PGM} nv_op_t;
endpackage

/* File: logic/sync2.sv */
// Two flip-flop synchroniser for a group of asynchronous inputs.
// Assumes each bit is stable long enough to be caught twice.
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // sync2
`default_nettype wire

/* File: logic/cycle_timer.sv */
// Down counter that flags the last cycle of a loaded interval.
// Assumes start and clear come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module cycle_timer #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic clear,
    input wire logic [WIDTH-1:0] load,
    // Status
    output logic done
);
    logic [WIDTH-1:0] cnt_r;
    assign done = (cnt_r == WIDTH'(1)) && !start && !clear;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (clear) begin
            cnt_r <= '0;
        end else if (start) begin
            cnt_r <= load;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - WIDTH'(1);
        end
    end
endmodule // cycle_timer
`default_nettype wire

/* File: tb/flash_host_model.sv */
// Host model: issues write and read cycles on the flash pins.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/100ps
`default_nettype none
module flash_host_model (
    // Clock
    input wire logic sys_clk,
    // Flash bus pins
    output logic ce_n,
    output logic we_n,
    output logic oe_n,
    output logic [18:0] addr,
    output logic [31:0] data
);
    initial begin
        {ce_n, we_n, oe_n} = 3'h7;
        addr = 19'h00000;
        data = 32'h0000_0000;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [18:0] a, input logic [31:0] d,
                      input logic oe);
        addr = a;
        data = d;
        ce_n = 1'b0;
        oe_n = oe;
        cyc(2);
        we_n = 1'b0;
        cyc(3);
        we_n = 1'b1;
        // Pins pass two flops, so hold until the rise is taken
        cyc(4);
        ce_n = 1'b1;
        oe_n = 1'b1;
        data = ~d;
    endtask
    // Strobes set directly, for a write held across reset
    task automatic hold(input logic [2:0] s, input logic [31:0] d);
        {ce_n, we_n, oe_n} = s;
        data = d;
    endtask
    task automatic rd(input logic [18:0] a);
        addr = a;
        ce_n = 1'b0;
        oe_n = 1'b0;
        cyc(4);
        ce_n = 1'b1;
        oe_n = 1'b1;
    endtask
endmodule // flash_host_model
`default_nettype wire

/* File: tb/tb_flash_sector_protect_ctrl.sv */
// Bench for the sector protection controller.
// Assumes the host model drives the bus pins other than wp_n.
`timescale 1ns/100ps
`default_nettype none
`include "flash_prot_defines.svh"
module tb_flash_sector_protect_ctrl;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic wp_n = 1'b1;
    logic lockout_voltage_low = 1'b0;
    logic pw_mode_locked = 1'b0;
    logic [31:0] verify_data_r;
    logic suspended_r;
    wire logic ce_n, we_n, oe_n;
    wire logic [18:0] addr;
    wire logic [31:0] data;
    flash_prot_pkg::grant_t grant_r;
    flash_prot_pkg::grant_t seen = '0;
    flash_prot_pkg::rd_sel_t rd_sel_r;
    logic busy_r, persistent_bit_lock_r, otp_enabled_r;
    int n_fail = 0;
    int n_checks = 0;
    flash_host_model u_flash_host_model (.sys_clk(sys_clk), .ce_n(ce_n),
        .we_n(we_n), .oe_n(oe_n), .addr(addr), .data(data));
    flash_sector_protect_ctrl #(.ERS_POLL_CYC(20)) u_flash_sector_protect_ctrl (
        .sys_clk(sys_clk), .rst(rst), .ce_n(ce_n), .we_n(we_n),
        .oe_n(oe_n), .wp_n(wp_n), .addr(addr), .data(data),
        .lockout_voltage_low(lockout_voltage_low), .opt01(1'b0),
        .pw_mode_locked(pw_mode_locked), .grant_r(grant_r), .ers_mask_r(),
        .op_addr_r(), .op_data_r(), .rd_sel_r(rd_sel_r),
        .verify_data_r(verify_data_r), .verify_valid_r(), .busy_r(busy_r),
        .persistent_bit_lock_r(persistent_bit_lock_r),
        .otp_enabled_r(otp_enabled_r), .suspended_r(suspended_r));
    always #5 sys_clk = ~sys_clk;
    // Grants last one cycle, so keep a sticky copy
    always @(posedge sys_clk) seen <= seen | grant_r;
    task automatic check(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cmd(input logic [18:0] a, input logic [7:0] c,
                       input logic oe, input logic [23:0] hi = 24'h000000);
        seen = '0;
        u_flash_host_model.wr(a, {hi, c}, oe);
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 300 && busy_r !== 1'b0; i++) @(posedge sys_clk);
        #1;
        if (busy_r !== 1'b0) begin
            n_fail++;
            finish_test();
        end
    endtask
    task automatic t_lock();
        check("lock after reset", persistent_bit_lock_r, 1'b0);
        cmd(19'h00000, `CMD_LOCK_SET, 1'b1);
        check("lock after set", persistent_bit_lock_r, 1'b1);
        cmd(19'h00001, `CMD_PW_UNLOCK, 1'b1);
        check("unlock busy", busy_r, 1'b0);
        check("lock kept", persistent_bit_lock_r, 1'b1);
    endtask
    task automatic t_wp();
        // pin held steady through the operation
        wp_n = 1'b0;
        cmd(19'h7F800, `CMD_PGM, 1'b1);
        check("blocked grant", seen.pgm, 1'b0);
        check("blocked busy", busy_r, 1'b1);
        u_flash_host_model.rd(19'h7F010);
        check("poll read", rd_sel_r, flash_prot_pkg::RD_STATUS);
        wait_idle();
        cmd(19'h28000, `CMD_PGM, 1'b1);
        check("other grant", seen.pgm, 1'b1);
        wp_n = 1'b1;
    endtask
    task automatic t_otp();
        cmd(19'h28000, `CMD_SUSPEND, 1'b1);
        check("suspended", suspended_r, 1'b1);
        cmd(19'h00000, `CMD_OTP_ENTRY, 1'b1);
        check("otp on", otp_enabled_r, 1'b1);
        u_flash_host_model.rd(19'h0003F);
        check("otp read", rd_sel_r, flash_prot_pkg::RD_OTP);
        u_flash_host_model.rd(19'h00040);
        check("overlay", rd_sel_r, flash_prot_pkg::RD_INVALID);
        cmd(19'h28000, `CMD_SUSPEND, 1'b1);
        check("suspend", seen.suspend, 1'b0);
        cmd(19'h28000, `CMD_RESUME, 1'b1);
        check("resume blocked", suspended_r, 1'b1);
        cmd(19'h00000, `CMD_DYN_WR, 1'b1, 24'h000001);
        cmd(19'h00000, `CMD_DYN_VFY, 1'b1);
        check("dyn verify", verify_data_r, `INVALID_DATA);
        cmd(19'h00000, `CMD_OTP_EXIT, 1'b1);
        check("otp off", otp_enabled_r, 1'b0);
        cmd(19'h00000, `CMD_DYN_VFY, 1'b1);
        check("dyn kept", verify_data_r, 32'h0000_0000);
        cmd(19'h28000, `CMD_RESUME, 1'b1);
        check("resume", seen.resume, 1'b1);
    endtask
    task automatic t_inhibit();
        cmd(19'h28000, `CMD_PGM, 1'b0);
        check("oe low grant", seen.pgm, 1'b0);
        lockout_voltage_low = 1'b1;
        cmd(19'h28000, `CMD_PGM, 1'b1);
        check("low supply grant", seen.pgm, 1'b0);
        check("low supply lock", persistent_bit_lock_r, 1'b0);
        lockout_voltage_low = 1'b0;
        cmd(19'h28000, `CMD_PGM, 1'b1);
        check("recovered grant", seen.pgm, 1'b1);
    endtask
    task automatic t_pw();
        cmd(19'h00000, `CMD_PW_PGM, 1'b1, 24'h5A5A5A);
        wait_idle();
        cmd(19'h00001, `CMD_PW_PGM, 1'b1, 24'hC3C3C3);
        wait_idle();
        cmd(19'h00001, `CMD_PW_VFY, 1'b1);
        check("pw read", verify_data_r, {24'hC3C3C3, `CMD_PW_PGM});
        pw_mode_locked = 1'b1;
        cmd(19'h00001, `CMD_PW_VFY, 1'b1);
        check("pw hidden", verify_data_r, 32'h0000_0000);
        cmd(19'h00000, `CMD_LOCK_SET, 1'b1);
        cmd(19'h00000, `CMD_PW_UNLOCK, 1'b1, 24'h5A5A5A);
        cmd(19'h00001, `CMD_PW_UNLOCK, 1'b1, 24'h000000);
        wait_idle();
        check("bad password", persistent_bit_lock_r, 1'b1);
        cmd(19'h00001, `CMD_PW_UNLOCK, 1'b1, 24'hC3C3C3);
        u_flash_host_model.rd(19'h00010);
        check("nv status", rd_sel_r, flash_prot_pkg::RD_STATUS);
        wait_idle();
        check("good password", persistent_bit_lock_r, 1'b0);
    endtask
    task automatic t_reset();
        rst = 1'b1;
        u_flash_host_model.hold(3'h1, {24'h000000, `CMD_OTP_ENTRY});
        repeat (8) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        u_flash_host_model.hold(3'h3, {24'h000000, `CMD_OTP_ENTRY});
        repeat (6) @(posedge sys_clk);
        #1;
        check("power-up write", otp_enabled_r, 1'b0);
        check("pw mode lock", persistent_bit_lock_r, 1'b1);
        u_flash_host_model.hold(3'h7, 32'h0000_0000);
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        t_lock();
        t_wp();
        t_otp();
        t_inhibit();
        t_pw();
        t_reset();
        finish_test();
    end
endmodule // tb_flash_sector_protect_ctrl
`default_nettype wire
